// ---- hdl/mb_map.sv ----
// Purpose: Modbus data mapper with link settings over APB.
// Assumes: Single 25 MHz clock; request events synchronous.
// Notes: i_restart stands for the module reset that applies settings.
`default_nettype none
module mb_map
    import mb_map_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    // Clock and reset.
    input  wire logic            i_clk,
    input  wire logic            i_rstn,
    // APB slave.
    input  wire logic            i_psel,
    input  wire logic            i_penable,
    input  wire logic            i_pwrite,
    input  wire logic [15:0]     i_paddr,
    input  wire logic [31:0]     i_pwdata,
    output logic      [31:0]     o_prdata,
    output logic                 o_pready,
    output logic                 o_pslverr,
    // Link side events.
    input  wire logic            i_req_valid,
    input  wire logic [7:0]      i_req_node,
    input  wire logic            i_restart,
    output logic                 o_req_accept,
    output link_cfg_s            o_link_cfg,
    output logic      [3:0]      o_char_bits,
    output logic                 o_live,
    output logic                 o_supervised,
    output logic                 o_cfg_err,
    // Diagnostic instances.
    input  wire logic [5:0]      i_diag_exist,
    input  wire logic [95:0]     i_diag_code
);
    // -----------------------------------------------------------------
    // State.
    // -----------------------------------------------------------------
    link_cfg_s   pend_ff, nxt_pend;   // Written settings.
    link_cfg_s   act_ff, nxt_act;     // Settings in force.
    logic [15:0] tmo_ff, nxt_tmo;     // Timeout in ticks.
    logic        err_ff, nxt_err;     // Runtime change seen.
    item_e       type_ff, nxt_type;   // Item type.
    logic [6:0]  cnt_ff, nxt_cnt;     // Element count.
    logic [63:0] data_ff, nxt_data;   // Internal item image.
    logic [1:0]  ridx_ff, nxt_ridx;   // Register selector.
    logic        live_ff, nxt_live;   // Traffic-live state.
    logic [15:0] left_ff, nxt_left;   // Ticks left.
    logic [31:0] tick_ff, nxt_tick;   // Cycle prescaler.
    logic [31:0] rd_ff, nxt_rd;       // Read data.
    logic        errsp_ff, nxt_errsp; // Slave error.

    logic [13:0] idx;
    logic        wr_en, rd_en, hit;
    logic [6:0]  cnt_eff;
    logic [2:0]  nreg;
    logic [63:0] keep;
    logic [63:0] mapped;

    assign idx   = i_paddr[15:2];
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && !i_penable && !i_pwrite;
    // A zero count means a single item.
    assign cnt_eff = (cnt_ff == 7'h00) ? 7'h01 : cnt_ff;

    // -----------------------------------------------------------------
    // Conversion: register count and kept-bit mask per type.
    // -----------------------------------------------------------------
    // One mask serves reads and writes, so both directions agree.
    always_comb
    begin
        nreg = 3'h1;
        keep = 64'h0;
        case (type_ff)
            boolean_item:
            begin
                // Element n in bit n, rest padded with zero.
                for (int b = 0; b < 64; b++)
                    keep[b] = (7'(b) < cnt_eff);
                // Widened sum: a 7-bit add would wrap for large counts.
                nreg = 3'((8'(cnt_eff) + 8'h0F) >> 4);
            end
            signed_byte_item, unsigned_byte_item, char_item, enum_item:
            begin
                for (int b = 0; b < 8; b++)
                    keep[8*b +: 8] = {8{7'(b) < cnt_eff}};
                nreg = 3'((8'(cnt_eff) + 8'h01) >> 1);
            end
            signed_halfword_item, unsigned_halfword_item:
            begin
                keep = 64'h0000_0000_0000_FFFF;
                nreg = 3'h1;
            end
            signed_word_item, unsigned_word_item, float_item:
            begin
                keep = 64'h0000_0000_FFFF_FFFF;
                nreg = 3'h2;
            end
            signed_dword_item, unsigned_dword_item:
            begin
                keep = 64'hFFFF_FFFF_FFFF_FFFF;
                nreg = 3'h4;
            end
            default:
            begin
                keep = 64'h0;
                nreg = 3'h1;
            end
        endcase
    end

    assign mapped = data_ff & keep;

    // -----------------------------------------------------------------
    // Register file, link settings and error flag.
    // -----------------------------------------------------------------
    always_comb
    begin
        logic [63:0] w;
        w         = data_ff;
        nxt_pend  = pend_ff;
        nxt_act   = act_ff;
        nxt_tmo   = tmo_ff;
        nxt_err   = err_ff;
        nxt_type  = type_ff;
        nxt_cnt   = cnt_ff;
        nxt_data  = data_ff;
        nxt_ridx  = ridx_ff;
        if (wr_en)
        begin
            case (idx)
                IX_NODE: nxt_pend.node = i_pwdata[7:0];
                IX_COMM:
                begin
                    // Rates above the top code are not taken.
                    if (i_pwdata[3:0] <= BAUD_MAX)
                        nxt_pend.baud = i_pwdata[3:0];
                    nxt_pend.parity = parity_e'(i_pwdata[5:4]);
                    nxt_pend.stop2  = i_pwdata[6];
                end
                IX_MODE: nxt_pend.ascii = i_pwdata[0];
                IX_TMO:  nxt_tmo = i_pwdata[15:0];
                IX_TYPE: nxt_type = item_e'(i_pwdata[3:0]);
                IX_CNT:  nxt_cnt = i_pwdata[6:0];
                IX_DLO:  nxt_data[31:0] = i_pwdata;
                IX_DHI:  nxt_data[63:32] = i_pwdata;
                IX_RIDX: nxt_ridx = i_pwdata[1:0];
                IX_RVAL:
                begin
                    // Register to internal uses the same mask.
                    w[16*ridx_ff +: 16] = i_pwdata[15:0];
                    nxt_data = w & keep;
                end
                default: nxt_data = data_ff;
            endcase
        end
        // A pending change differing from the active set is an error.
        if (nxt_pend != act_ff)
            nxt_err = 1'b1;
        if (i_restart)
        begin
            nxt_act = nxt_pend;
            nxt_err = 1'b0;
        end
    end

    always_comb
    begin
        logic [15:0] dv;
        dv        = 16'h0000;
        nxt_rd    = 32'h0000_0000;
        nxt_errsp = 1'b0;
        hit       = 1'b1;
        case (idx)
            IX_NODE: nxt_rd = {24'h0, pend_ff.node};
            IX_COMM: nxt_rd = {25'h0, pend_ff.stop2, pend_ff.parity, pend_ff.baud};
            IX_MODE: nxt_rd = {31'h0, pend_ff.ascii};
            IX_TMO:  nxt_rd = {16'h0, tmo_ff};
            IX_TYPE: nxt_rd = {28'h0, type_ff};
            IX_CNT:  nxt_rd = {25'h0, cnt_ff};
            IX_DLO:  nxt_rd = data_ff[31:0];
            IX_DHI:  nxt_rd = data_ff[63:32];
            IX_RIDX: nxt_rd = {30'h0, ridx_ff};
            IX_RVAL: nxt_rd = {16'h0, mapped[16*ridx_ff +: 16]};
            IX_NREG: nxt_rd = {29'h0, nreg};
            IX_STAT: nxt_rd = {30'h0, err_ff, live_ff};
            default:
            begin
                if (idx >= IX_DIAG && idx < IX_DIAG + 14'(NDIAG))
                begin
                    // Each slot is one fixed instance; absent reads zero.
                    for (int d = 0; d < NDIAG; d++)
                        if (idx == IX_DIAG + 14'(d) && i_diag_exist[d])
                            dv = i_diag_code[16*d +: 16];
                    nxt_rd = {16'h0, dv};
                end
                else
                begin
                    hit = 1'b0;
                    nxt_errsp = 1'b1;
                end
            end
        endcase
        if (!rd_en)
        begin
            nxt_rd    = rd_ff;
            nxt_errsp = i_psel && !i_penable && !hit;
        end
    end

    // -----------------------------------------------------------------
    // Traffic-live timer.
    // -----------------------------------------------------------------
    always_comb
    begin
        nxt_live = live_ff;
        nxt_left = left_ff;
        nxt_tick = tick_ff;
        if (o_req_accept)
        begin
            nxt_live = 1'b1;
            nxt_left = tmo_ff;
            nxt_tick = 32'h0;
        end
        else if (live_ff && tmo_ff != TMO_RST)
        begin
            if (tick_ff == 32'(TICK_CYCLES - 1))
            begin
                nxt_tick = 32'h0;
                if (left_ff <= 16'h1)
                    nxt_live = 1'b0;
                else
                    nxt_left = left_ff - 16'h1;
            end
            else
                nxt_tick = tick_ff + 32'h1;
        end
    end

    // -----------------------------------------------------------------
    // Flip-flops.
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pend_ff <= '{NODE_RST, BAUD_RST, par_none, 1'b0, 1'b0};
            act_ff  <= '{NODE_RST, BAUD_RST, par_none, 1'b0, 1'b0};
            tmo_ff  <= TMO_RST;
            err_ff  <= 1'b0;
            type_ff <= boolean_item;
            cnt_ff  <= 7'h00;
            data_ff <= 64'h0;
            ridx_ff <= 2'h0;
            live_ff <= 1'b0;
            left_ff <= 16'h0;
            tick_ff <= 32'h0;
            rd_ff   <= 32'h0;
            errsp_ff <= 1'b0;
        end
        else
        begin
            pend_ff <= nxt_pend;
            act_ff  <= nxt_act;
            tmo_ff  <= nxt_tmo;
            err_ff  <= nxt_err;
            type_ff <= nxt_type;
            cnt_ff  <= nxt_cnt;
            data_ff <= nxt_data;
            ridx_ff <= nxt_ridx;
            live_ff <= nxt_live;
            left_ff <= nxt_left;
            tick_ff <= nxt_tick;
            rd_ff   <= nxt_rd;
            errsp_ff <= nxt_errsp;
        end
    end

    // -----------------------------------------------------------------
    // Outputs.
    // -----------------------------------------------------------------
    assign o_pready     = 1'b1;
    assign o_prdata     = rd_ff;
    assign o_pslverr    = errsp_ff && i_psel && i_penable;
    // Matching against the active set keeps old address until reset.
    assign o_req_accept = i_req_valid && (i_req_node == act_ff.node);
    assign o_link_cfg   = act_ff;
    assign o_char_bits  = act_ff.ascii ? 4'h7 : 4'h8;
    assign o_live       = live_ff;
    assign o_supervised = live_ff;
    assign o_cfg_err    = err_ff;

    // -----------------------------------------------------------------
    // Assertions.
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    addr_filter_a: assert property (i_req_valid && i_req_node != act_ff.node |-> !o_req_accept)
        else $error("foreign node accepted");
    live_start_a: assert property (o_req_accept |=> live_ff)
        else $error("live not set");
    live_hold_a: assert property (live_ff && tmo_ff == TMO_RST |=> live_ff)
        else $error("live dropped while disabled");
    keep_act_a: assert property (!i_restart |=> act_ff == $past(act_ff))
        else $error("active set changed early");
    err_flag_a: assert property (wr_en && idx == IX_NODE && i_pwdata[7:0] != act_ff.node
        && !i_restart |=> o_cfg_err)
        else $error("no config error");
    half_map_a: assert property (type_ff == unsigned_halfword_item |-> nreg == 3'h1 && keep[16] == 1'b0)
        else $error("halfword map");
    word_map_a: assert property (type_ff == float_item |-> nreg == 3'h2)
        else $error("word map");
    dword_map_a: assert property (type_ff == signed_dword_item |-> nreg == 3'h4)
        else $error("dword map");
    byte_pad_a: assert property (type_ff == char_item && cnt_ff == 7'h01 |-> keep[15:8] == 8'h00)
        else $error("byte pad");
    boolean_item_pad_a: assert property (type_ff == boolean_item && cnt_ff == 7'h03 |-> keep[15:0] == 16'h0007)
        else $error("boolean_item pad");
    // A restart must hand the pending framing mode to the character width.
    char_width_a: assert property (i_restart && !wr_en |=> (o_char_bits == 4'h7) == $past(pend_ff.ascii))
        else $error("char width");

    live_c: cover property (o_req_accept ##1 live_ff);
    restart_c: cover property (o_cfg_err ##1 i_restart);
    rval_c: cover property (wr_en && idx == IX_RVAL);
endmodule // mb_map
`default_nettype wire

// ---- hdl/mb_map_pkg.sv ----
// Purpose: Constants and types for the Modbus data mapper.
// Assumes: APB word registers; byte address is four times the index.
// Notes: The rule summary below covers the whole block.
// Summary of operation
// - Booleans become zero-padded 16-bit bit fields.
// - Bytes padded alone, packed two per register.
// - Characters padded alone, packed two per register.
// - Enums padded alone, 8-bit arrays packed.
// - 16-bit integers take exactly one register.
// - 32-bit integers and floats take two.
// - 64-bit integers take four registers.
// - Same conversion used in both directions.
// - Answer only our own node address.
// - Rates to 115.2k, parity, one/two stops.
// - RTU 8-bit or ASCII 7-bit framing.
// - Request restarts traffic-live timeout; drives supervised.
// - Link settings readable and writable.
// - Diagnostic entries fixed; missing ones read zero.
// - Link settings apply after reset; change flags error.
// - Old link settings kept until reset.
// - Settings at holding registers 0200h to 0203h.
// - Timeout disabled by default: live forever.
`default_nettype none
package mb_map_pkg;
    // -----------------------------------------------------------------
    // Register indices (byte address = index * 4).
    // -----------------------------------------------------------------
    localparam logic [13:0] IX_NODE    = 14'h0200;
    localparam logic [13:0] IX_COMM    = 14'h0201;
    localparam logic [13:0] IX_MODE    = 14'h0202;
    localparam logic [13:0] IX_TMO     = 14'h0203;
    localparam logic [13:0] IX_TYPE    = 14'h0300;
    localparam logic [13:0] IX_CNT     = 14'h0301;
    localparam logic [13:0] IX_DLO     = 14'h0302;
    localparam logic [13:0] IX_DHI     = 14'h0303;
    localparam logic [13:0] IX_RIDX    = 14'h0304;
    localparam logic [13:0] IX_RVAL    = 14'h0305;
    localparam logic [13:0] IX_NREG    = 14'h0306;
    localparam logic [13:0] IX_STAT    = 14'h0307;
    localparam logic [13:0] IX_DIAG    = 14'h0310;
    localparam int          NDIAG      = 6;
    // -----------------------------------------------------------------
    // Reset values and limits.
    // -----------------------------------------------------------------
    localparam logic [7:0]  NODE_RST   = 8'h01;
    localparam logic [3:0]  BAUD_RST   = 4'h4;
    localparam logic [3:0]  BAUD_MAX   = 4'h7;
    localparam logic [15:0] TMO_RST    = 16'h0000;
    localparam int          CLK_HZ     = 25000000;
    localparam int          TICK_MS    = 1;
    localparam int          TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
    // -----------------------------------------------------------------
    // Types.
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {par_none, par_odd, par_even} parity_e;
    typedef enum logic [3:0] {
        boolean_item, signed_byte_item, unsigned_byte_item, char_item,
        enum_item, signed_halfword_item, unsigned_halfword_item,
        signed_word_item, unsigned_word_item, float_item,
        signed_dword_item, unsigned_dword_item
    } item_e;
    typedef struct packed {
        logic [7:0]  node;
        logic [3:0]  baud;
        parity_e     parity;
        logic        stop2;
        logic        ascii;
    } link_cfg_s;
endpackage
`default_nettype wire

// ---- bench/mb_master_model.sv ----
// Purpose: Link master model that issues request events.
// Assumes: It uses the rate, parity, stops and framing we hold.
// Notes: The node bus carries the inverse of the last node when idle.
`default_nettype none
module mb_master_model (
    // Request side.
    input  wire logic       i_clk,
    input  wire logic       i_req_accept,
    output logic            o_req_valid,
    output logic [7:0]      o_req_node
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_req_valid = 1'b0;
        o_req_node  = 8'h00;
    end
    // Sends one request and reports whether the node took it.
    task automatic send(input logic [7:0] node, output logic acc);
        @(posedge i_clk);
        o_req_valid <= 1'b1;
        o_req_node  <= node;
        @(posedge i_clk);
        acc = i_req_accept;
        o_req_valid <= 1'b0;
        o_req_node  <= ~node;
    endtask
endmodule // mb_master_model
`default_nettype wire

// ---- bench/modbus_data_mapper_tb.sv ----
// Purpose: Self-checking bench for the data mapper.
// Assumes: Zero wait state APB; tick shortened to 4 cycles.
// Notes: Each scenario is one task that judges its own results.
`default_nettype none
module modbus_data_mapper_tb
    import mb_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk, i_rstn, psel, pen, pwr, restart, rv, pready, perr, acc;
    logic        live, sup, cerr;
    logic [15:0] paddr;
    logic [31:0] pwd, prd, rd;
    logic [7:0]  rnode;
    logic [3:0]  cbits;
    logic [5:0]  dex;
    logic [95:0] dcode;
    link_cfg_s   cfg, ecfg;
    int          n_fail, checks_done;
    always #20 i_clk = ~i_clk;
    mb_map #(.TICK_CYCLES(4)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(pready), .o_pslverr(perr), .i_req_valid(rv), .i_req_node(rnode),
        .i_restart(restart), .o_req_accept(acc), .o_link_cfg(cfg), .o_char_bits(cbits),
        .o_live(live), .o_supervised(sup), .o_cfg_err(cerr), .i_diag_exist(dex),
        .i_diag_code(dcode));
    mb_master_model mst_u (.i_clk(i_clk), .i_req_accept(acc), .o_req_valid(rv), .o_req_node(rnode));
    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One comparison of an expected against a seen value.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [13:0] ix, input logic [31:0] wd,
                       output logic [31:0] d, output logic er);
        int n;
        @(posedge i_clk);
        psel  <= 1'b1;
        pen   <= 1'b0;
        pwr   <= w;
        paddr <= {ix, 2'b00};
        pwd   <= wd;
        @(posedge i_clk);
        pen <= 1'b1;
        n = 0;
        @(posedge i_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge i_clk);
            n++;
        end
        d  = prd;
        er = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (n >= 20)
        begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic wr(input logic [13:0] ix, input logic [31:0] wd);
        logic er;
        apb(1'b1, ix, wd, rd, er);
    endtask
    task automatic rchk(input string nm, input logic [13:0] ix, input logic [31:0] e);
        logic er;
        apb(1'b0, ix, 32'h0, rd, er);
        chk(nm, e, rd);
    endtask
    // Sends a request and compares the accept answer.
    task automatic req(input logic [7:0] nd, input logic e);
        logic a;
        mst_u.send(nd, a);
        chk("accept", {31'h0, e}, {31'h0, a});
    endtask
    // Width of the masked value for a type and count.
    function automatic int nbits(input logic [3:0] t, input logic [6:0] c);
        int n;
        n = (c == 0) ? 1 : c;
        case (t)
            4'h0: return n;
            4'h1, 4'h2, 4'h3, 4'h4: return 8 * n;
            4'h5, 4'h6: return 16;
            4'h7, 4'h8, 4'h9: return 32;
            default: return 64;
        endcase
    endfunction
    task automatic t_reset();
        ecfg = '{node: 8'h01, baud: 4'h4, parity: par_none, stop2: 1'b0, ascii: 1'b0};
        chk("cfg", 32'(ecfg), 32'(cfg));
        chk("cbits", 32'h8, {28'h0, cbits});
        rchk("node", IX_NODE, 32'h1);
        rchk("comm", IX_COMM, 32'h4);
        rchk("mode", IX_MODE, 32'h0);
        rchk("tmo", IX_TMO, 32'h0);
        rchk("stat", IX_STAT, 32'h0);
    endtask
    task automatic t_node();
        req(8'h01, 1'b1);
        #1 chk("live", 32'h1, {31'h0, live});
        chk("sup", 32'h1, {31'h0, sup});
        req(8'h02, 1'b0);
        repeat (40) @(posedge i_clk);
        #1 chk("live", 32'h1, {31'h0, live});
    endtask
    // Every item type through the register window, all four slices.
    task automatic t_map();
        logic [3:0]  ty [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'h0};
        logic [6:0]  cn [13] = '{7'h03, 7'h00, 7'h03, 7'h02, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01,
                                 7'h01, 7'h01, 7'h11};
        logic [63:0] dv, mk, ev;
        int          b;
        dv = 64'hF0E1_D2C3_B4A5_9687;
        for (int i = 0; i < 13; i++)
        begin
            b  = nbits(ty[i], cn[i]);
            mk = (b == 64) ? '1 : ((64'h1 << b) - 64'h1);
            ev = dv & mk;
            wr(IX_TYPE, {28'h0, ty[i]});
            wr(IX_CNT, {25'h0, cn[i]});
            wr(IX_DLO, dv[31:0]);
            wr(IX_DHI, dv[63:32]);
            rchk("nreg", IX_NREG, 32'((b + 15) / 16));
            for (int s = 0; s < 4; s++)
            begin
                wr(IX_RIDX, 32'(s));
                rchk("rval", IX_RVAL, {16'h0, ev[16*s+:16]});
            end
        end
        wr(IX_TYPE, 32'h2);
        wr(IX_CNT, 32'h1);
        wr(IX_RIDX, 32'h0);
        wr(IX_RVAL, 32'hFFFF);
        rchk("back", IX_RVAL, 32'h00FF);
    endtask
    // Runtime change stays pending until the restart.
    task automatic t_settings();
        wr(IX_NODE, 32'h05);
        wr(IX_COMM, 32'h65);
        wr(IX_MODE, 32'h1);
        wr(IX_TMO, 32'h2);
        rchk("node", IX_NODE, 32'h05);
        rchk("comm", IX_COMM, 32'h65);
        rchk("mode", IX_MODE, 32'h1);
        rchk("tmo", IX_TMO, 32'h2);
        chk("err", 32'h1, {31'h0, cerr});
        chk("cfg", 32'(ecfg), 32'(cfg));
        req(8'h05, 1'b0);
        req(8'h01, 1'b1);
        wr(IX_COMM, 32'h68);
        rchk("baud", IX_COMM, 32'h65);
        @(posedge i_clk);
        restart <= 1'b1;
        @(posedge i_clk);
        restart <= 1'b0;
        ecfg = '{node: 8'h05, baud: 4'h5, parity: par_even, stop2: 1'b1, ascii: 1'b1};
        #1 chk("cfg", 32'(ecfg), 32'(cfg));
        chk("cbits", 32'h7, {28'h0, cbits});
        chk("err", 32'h0, {31'h0, cerr});
        req(8'h05, 1'b1);
    endtask
    // Timeout of two ticks of four cycles each.
    task automatic t_timeout();
        req(8'h05, 1'b1);
        repeat (5) @(posedge i_clk);
        #1 chk("live", 32'h1, {31'h0, live});
        repeat (6) @(posedge i_clk);
        #1 chk("live", 32'h0, {31'h0, live});
        chk("sup", 32'h0, {31'h0, sup});
    endtask
    task automatic t_diag();
        logic er;
        for (int d = 0; d < 6; d++)
            rchk("diag", IX_DIAG + 14'(d), dex[d] ? {16'h0, dcode[16*d+:16]} : 32'h0);
        apb(1'b0, 14'h0250, 32'h0, rd, er);
        chk("slverr", 32'h1, {31'h0, er});
        chk("rdata", 32'h0, rd);
    endtask
    initial
    begin
        i_clk = 1'b0;
        i_rstn = 1'b0;
        {psel, pen, pwr, restart} = 4'h0;
        paddr = 16'h0000;
        pwd = 32'h0;
        dex = 6'h25;
        dcode = 96'h6666_5555_4444_3333_2222_1111;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        #1 t_reset();
        t_node();
        t_map();
        t_settings();
        t_timeout();
        t_diag();
        close_out();
    end
endmodule // modbus_data_mapper_tb
`default_nettype wire
